//--- inc/lbp_pkg.sv
/*
 package of the local transfer buffer port: widths, reset levels,
 direction codes, timing counts and the link state type.
 assumes nothing of its surroundings.
*/
package lbp_pkg;
    localparam int   WORD_W         = 16;
    localparam int   COUNT_W        = 16;
    // reset levels of the link outputs
    localparam logic REQ_RST        = 1'h1;
    localparam logic LOAD_RST       = 1'h1;
    localparam logic DIR_RST        = 1'h1;
    localparam logic CHAN_RST       = 1'h0;
    // direction codes
    localparam logic DIR_TO_BOARD   = 1'h1;
    localparam logic DIR_FROM_BOARD = 1'h0;
    // channel codes
    localparam logic CHAN_0         = 1'h0;
    localparam logic CHAN_1         = 1'h1;
    // recommended link clock range in mhz
    localparam int   PORT_MHZ_MIN   = 16;
    localparam int   PORT_MHZ_MAX   = 20;
    // idle link clocks the far end keeps after each acknowledge
    localparam logic [1:0] ACK_GAP  = 2'h3;
    localparam logic [WORD_W-1:0] BUS_PULLUP = 16'hffff;

    typedef enum logic [1:0] {
        P_IDLE,
        P_LOAD,
        P_XFER,
        P_END
    } lbp_state_type;
endpackage : lbp_pkg

//--- inc/lbp_link_if.sv
/*
 link between the documented device end and the transfer buffer logic.
 assumes the bench drives port_clock and resolves nothing else;
 the shared word bus and end-of-process wire are resolved here.
*/
`timescale 1ns/1ps
interface lbp_link_if (
    input wire logic port_clock
);
    logic                           xfer_request_n;
    logic                           xfer_acknowledge_n;
    logic                           addr_counter_load_n;
    logic                           xfer_direction;
    logic                           channel_select;
    logic                           word_bus_output_disable_n;
    logic [lbp_pkg::WORD_W-1:0]     dev_bus_o;
    logic                           dev_bus_oe;
    logic [lbp_pkg::WORD_W-1:0]     host_bus_o;
    logic                           host_bus_oe;
    logic [lbp_pkg::WORD_W-1:0]     local_word_bus;
    logic                           end_of_process_o;
    logic                           end_of_process_oe;
    logic                           end_of_process_n;

    // wire resolution, pull-ups when nobody drives
    assign local_word_bus   = dev_bus_oe ? dev_bus_o : (host_bus_oe ? host_bus_o : lbp_pkg::BUS_PULLUP);
    assign end_of_process_n = end_of_process_oe ? end_of_process_o : 1'h1;

    modport dev (
        input  port_clock,
        output xfer_request_n,
        input  xfer_acknowledge_n,
        output addr_counter_load_n,
        output xfer_direction,
        output channel_select,
        input  word_bus_output_disable_n,
        output dev_bus_o,
        output dev_bus_oe,
        input  local_word_bus,
        output end_of_process_o,
        output end_of_process_oe
    );

    modport host (
        input  port_clock,
        input  xfer_request_n,
        output xfer_acknowledge_n,
        input  addr_counter_load_n,
        input  xfer_direction,
        input  channel_select,
        output word_bus_output_disable_n,
        output host_bus_o,
        output host_bus_oe,
        input  local_word_bus,
        input  end_of_process_n
    );
endinterface : lbp_link_if

//--- verilog/lbp_host.sv
/*
 transfer buffer logic end: address counter, acknowledge pacing and
 the buffer access strobes.
 assumes every input is synchronous to port_clock, resetn included,
 and a buffer that answers buf_rdata combinationally at buf_rd_addr.
*/
`timescale 1ns/1ps
module lbp_host (
    input  wire logic                        resetn,
    input  wire logic                        clk_en,
    input  wire logic                        bus_disable,
    input  wire logic                        buf_ready,
    input  wire logic [lbp_pkg::WORD_W-1:0]  buf_rdata,
    output logic      [lbp_pkg::WORD_W-1:0]  buf_rd_addr,
    output logic                             buf_rd,
    output logic      [lbp_pkg::WORD_W-1:0]  buf_wr_addr,
    output logic      [lbp_pkg::WORD_W-1:0]  buf_wdata,
    output logic                             buf_wr,
    output logic      [lbp_pkg::WORD_W-1:0]  start_addr,
    output logic                             cur_channel,
    output logic                             xfer_end,
    lbp_link_if.host                         link
);
    logic [1:0]                  gap;
    logic                        ack_n;
    logic [lbp_pkg::WORD_W-1:0]  bus_o;
    logic                        bus_oe;

    assign link.xfer_acknowledge_n        = ack_n;
    assign link.host_bus_o                = bus_o;
    assign link.host_bus_oe               = bus_oe;
    assign link.word_bus_output_disable_n = bus_disable;

    // bus drive while the device reads words from the board
    always_ff @(posedge link.port_clock) begin
        if (!resetn) begin
            bus_oe <= 1'h0;
        end else if (clk_en) begin
            bus_oe <= !link.xfer_request_n && link.xfer_direction == lbp_pkg::DIR_FROM_BOARD;
        end
    end

    // end of process seen on the wire
    always_ff @(posedge link.port_clock) begin
        if (!resetn) begin
            xfer_end <= 1'h0;
        end else if (clk_en) begin
            xfer_end <= !link.end_of_process_n;
        end
    end

    // address counter and acknowledge pacing
    always_ff @(posedge link.port_clock) begin
        if (!resetn) begin
            gap         <= 2'h0;
            ack_n       <= 1'h1;
            bus_o       <= '0;
            buf_rd_addr <= '0;
            buf_wr_addr <= '0;
            buf_wdata   <= '0;
            buf_rd      <= 1'h0;
            buf_wr      <= 1'h0;
            start_addr  <= '0;
            cur_channel <= lbp_pkg::CHAN_0;
        end else if (clk_en) begin
            ack_n  <= 1'h1;
            buf_rd <= 1'h0;
            buf_wr <= 1'h0;
            if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end else if (!link.addr_counter_load_n) begin
                start_addr  <= link.local_word_bus;
                buf_rd_addr <= link.local_word_bus;
                cur_channel <= link.channel_select;
                ack_n       <= 1'h0;
                gap         <= lbp_pkg::ACK_GAP;
            end else if (!link.xfer_request_n && buf_ready) begin
                ack_n       <= 1'h0;
                gap         <= lbp_pkg::ACK_GAP;
                buf_rd_addr <= buf_rd_addr + 16'h1;
                if (link.xfer_direction == lbp_pkg::DIR_TO_BOARD) begin
                    buf_wr_addr <= buf_rd_addr;
                    buf_wdata   <= link.local_word_bus;
                    buf_wr      <= 1'h1;
                end else begin
                    bus_o  <= buf_rdata;
                    buf_rd <= 1'h1;
                end
            end
        end
    end
endmodule : lbp_host

//--- verilog/lbp_device.sv
/*
 device end of the local transfer buffer port: command and word
 crossings between mclk and the link clock, and the link sequencer.
 assumes the link clock comes from the far end through the interface
 and that the far end keeps at least three idle clocks after an acknowledge.
*/
`timescale 1ns/1ps
module lbp_device (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic                          clk_en,
    input  wire logic                          cmd_valid,
    output logic                               cmd_ready,
    input  wire logic                          cmd_channel,
    input  wire logic                          cmd_dir,
    input  wire logic [lbp_pkg::WORD_W-1:0]    cmd_addr,
    input  wire logic [lbp_pkg::COUNT_W-1:0]   cmd_count,
    input  wire logic                          abort,
    input  wire logic                          wr_valid,
    output logic                               wr_ready,
    input  wire logic [lbp_pkg::WORD_W-1:0]    wr_data,
    output logic                               rd_valid,
    input  wire logic                          rd_ready,
    output logic      [lbp_pkg::WORD_W-1:0]    rd_data,
    output logic                               xfer_done,
    lbp_link_if.dev                            link
);
    // mclk domain
    logic                          cmd_tgl;
    logic                          cmd_channel_q;
    logic                          cmd_dir_q;
    logic [lbp_pkg::WORD_W-1:0]    cmd_addr_q;
    logic [lbp_pkg::COUNT_W-1:0]   cmd_count_q;
    logic                          done_s1;
    logic                          done_s2;
    logic                          done_s3;
    logic                          out_tgl;
    logic [lbp_pkg::WORD_W-1:0]    out_data;
    logic                          outack_s1;
    logic                          outack_s2;
    logic                          in_s1;
    logic                          in_s2;
    logic                          in_seen;
    // link domain
    logic                          prst_s1;
    logic                          prst_n;
    logic                          pen_s1;
    logic                          pen;
    logic                          cmd_s1;
    logic                          cmd_s2;
    logic                          cmd_seen;
    logic                          abort_s1;
    logic                          abort_s2;
    logic                          out_s1;
    logic                          out_s2;
    logic                          out_seen;
    logic                          in_tgl;
    logic [lbp_pkg::WORD_W-1:0]    in_data;
    logic                          inack_s1;
    logic                          inack_s2;
    logic                          ack_q;
    logic                          dis_q;
    logic [lbp_pkg::WORD_W-1:0]    bus_q;
    lbp_pkg::lbp_state_type        state;
    logic                          req_n;
    logic                          load_n;
    logic                          dir;
    logic                          chan;
    logic                          eop;
    logic [lbp_pkg::WORD_W-1:0]    bus_o;
    logic [lbp_pkg::COUNT_W-1:0]   remaining;
    logic                          word_ok;
    logic                          drive;

    // handshake outputs toward the user
    assign cmd_ready = (cmd_tgl == done_s2);
    assign wr_ready  = (out_tgl == outack_s2);
    assign rd_valid  = (in_s2 != in_seen);
    assign rd_data   = in_data;

    // command capture, held until the link reports the end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cmd_tgl       <= 1'h0;
            cmd_channel_q <= lbp_pkg::CHAN_0;
            cmd_dir_q     <= lbp_pkg::DIR_TO_BOARD;
            cmd_addr_q    <= '0;
            cmd_count_q   <= '0;
        end else if (clk_en && cmd_valid && cmd_ready) begin
            cmd_tgl       <= ~cmd_tgl;
            cmd_channel_q <= cmd_channel;
            cmd_dir_q     <= cmd_dir;
            cmd_addr_q    <= cmd_addr;
            cmd_count_q   <= cmd_count;
        end
    end

    // end of transfer back into mclk
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            done_s1   <= 1'h0;
            done_s2   <= 1'h0;
            done_s3   <= 1'h0;
            xfer_done <= 1'h0;
        end else if (clk_en) begin
            done_s1   <= cmd_seen;
            done_s2   <= done_s1;
            done_s3   <= done_s2;
            xfer_done <= done_s2 != done_s3;
        end
    end

    // words toward the board
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            out_tgl   <= 1'h0;
            out_data  <= '0;
            outack_s1 <= 1'h0;
            outack_s2 <= 1'h0;
        end else if (clk_en) begin
            outack_s1 <= out_seen;
            outack_s2 <= outack_s1;
            if (wr_valid && wr_ready) begin
                out_tgl  <= ~out_tgl;
                out_data <= wr_data;
            end
        end
    end

    // words from the board
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            in_s1   <= 1'h0;
            in_s2   <= 1'h0;
            in_seen <= 1'h0;
        end else if (clk_en) begin
            in_s1 <= in_tgl;
            in_s2 <= in_s1;
            if (rd_valid && rd_ready) begin
                in_seen <= ~in_seen;
            end
        end
    end

    // reset and clock enable into the link domain
    always_ff @(posedge link.port_clock) begin
        prst_s1 <= resetn;
        prst_n  <= prst_s1;
        pen_s1  <= clk_en;
        pen     <= pen_s1;
    end

    // crossings and link inputs
    always_ff @(posedge link.port_clock) begin
        if (!prst_n) begin
            cmd_s1   <= 1'h0;
            cmd_s2   <= 1'h0;
            abort_s1 <= 1'h0;
            abort_s2 <= 1'h0;
            out_s1   <= 1'h0;
            out_s2   <= 1'h0;
            inack_s1 <= 1'h0;
            inack_s2 <= 1'h0;
            ack_q    <= 1'h0;
            dis_q    <= 1'h0;
            bus_q    <= '0;
        end else if (pen) begin
            cmd_s1   <= cmd_tgl;
            cmd_s2   <= cmd_s1;
            abort_s1 <= abort;
            abort_s2 <= abort_s1;
            out_s1   <= out_tgl;
            out_s2   <= out_s1;
            inack_s1 <= in_seen;
            inack_s2 <= inack_s1;
            ack_q    <= !link.xfer_acknowledge_n;
            dis_q    <= link.word_bus_output_disable_n;
            bus_q    <= link.local_word_bus;
        end
    end

    assign word_ok = (dir == lbp_pkg::DIR_TO_BOARD) ? (out_s2 != out_seen) : (in_tgl == inack_s2);

    // link sequencer
    always_ff @(posedge link.port_clock) begin
        if (!prst_n) begin
            state     <= lbp_pkg::P_IDLE;
            req_n     <= lbp_pkg::REQ_RST;
            load_n    <= lbp_pkg::LOAD_RST;
            dir       <= lbp_pkg::DIR_RST;
            chan      <= lbp_pkg::CHAN_RST;
            eop       <= 1'h0;
            bus_o     <= '0;
            remaining <= '0;
            cmd_seen  <= 1'h0;
            out_seen  <= 1'h0;
            in_tgl    <= 1'h0;
            in_data   <= '0;
        end else if (pen) begin
            unique case (state)
                lbp_pkg::P_IDLE: begin
                    if (cmd_s2 != cmd_seen) begin
                        dir       <= cmd_dir_q;
                        chan      <= cmd_channel_q;
                        remaining <= cmd_count_q;
                        bus_o     <= cmd_addr_q;
                        load_n    <= 1'h0;
                        state     <= lbp_pkg::P_LOAD;
                    end
                end
                lbp_pkg::P_LOAD: begin
                    if (ack_q) begin
                        load_n <= 1'h1;
                        state  <= lbp_pkg::P_XFER;
                    end
                end
                lbp_pkg::P_XFER: begin
                    if (abort_s2) begin
                        req_n <= 1'h1;
                        eop   <= 1'h1;
                        state <= lbp_pkg::P_END;
                    end else if (ack_q && !req_n) begin
                        req_n <= 1'h1;
                        if (dir == lbp_pkg::DIR_TO_BOARD) begin
                            out_seen <= out_s2;
                        end else begin
                            in_data <= bus_q;
                            in_tgl  <= ~in_tgl;
                        end
                        if (remaining <= 16'h1) begin
                            eop   <= 1'h1;
                            state <= lbp_pkg::P_END;
                        end else begin
                            remaining <= remaining - 16'h1;
                        end
                    end else begin
                        req_n <= !word_ok;
                        bus_o <= out_data;
                    end
                end
                lbp_pkg::P_END: begin
                    eop      <= 1'h0;
                    cmd_seen <= cmd_s2;
                    state    <= lbp_pkg::P_IDLE;
                end
            endcase
        end
    end

    // bus drive: address on load, data only toward the board
    assign drive = (state == lbp_pkg::P_LOAD) || (state == lbp_pkg::P_XFER && dir == lbp_pkg::DIR_TO_BOARD);

    assign link.xfer_request_n      = req_n;
    assign link.addr_counter_load_n = load_n;
    assign link.xfer_direction      = dir;
    assign link.channel_select      = chan;
    assign link.dev_bus_o           = bus_o;
    assign link.dev_bus_oe          = drive && !dis_q && !link.word_bus_output_disable_n;
    assign link.end_of_process_o    = 1'h0;
    assign link.end_of_process_oe   = eop;
endmodule : lbp_device

//--- verif/lbp_link_properties.sv
/*
 checker of the link between the device end and the buffer logic.
 assumes signals sampled on port_clock and resetn held low >= 5 link clocks.
*/
`timescale 1ns/1ps
module lbp_link_properties (
    input wire logic port_clock,
    input wire logic resetn,
    input wire logic xfer_request_n,
    input wire logic xfer_acknowledge_n,
    input wire logic addr_counter_load_n,
    input wire logic xfer_direction,
    input wire logic channel_select,
    input wire logic word_bus_output_disable_n,
    input wire logic dev_bus_oe,
    input wire logic end_of_process_n
);
    property p_load_hold;
        @(posedge port_clock) disable iff (!resetn)
        !addr_counter_load_n && xfer_acknowledge_n && $past(xfer_acknowledge_n) && $past(xfer_acknowledge_n, 2)
        |=> !addr_counter_load_n;
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("load strobe left early");
    property p_load_end;
        @(posedge port_clock) disable iff (!resetn) !addr_counter_load_n && !xfer_acknowledge_n |-> ##[1:3] addr_counter_load_n;
    endproperty
    a_load_end: assert property (p_load_end) else $error("load strobe stuck after acknowledge");
    property p_req_end;
        @(posedge port_clock) disable iff (!resetn) !xfer_request_n && !xfer_acknowledge_n |-> ##[1:3] xfer_request_n;
    endproperty
    a_req_end: assert property (p_req_end) else $error("request stuck after acknowledge");
    property p_dir_steady;
        @(posedge port_clock) disable iff (!resetn) !xfer_request_n && !$past(xfer_request_n) |-> $stable(xfer_direction);
    endproperty
    a_dir_steady: assert property (p_dir_steady) else $error("direction moved under request");
    property p_chan_steady;
        @(posedge port_clock) disable iff (!resetn)
        (!addr_counter_load_n || !xfer_request_n) && !($past(addr_counter_load_n) && $past(xfer_request_n))
        |-> $stable(channel_select);
    endproperty
    a_chan_steady: assert property (p_chan_steady) else $error("channel moved under strobe");
    property p_disable;
        @(posedge port_clock) disable iff (!resetn) word_bus_output_disable_n |-> !dev_bus_oe;
    endproperty
    a_disable: assert property (p_disable) else $error("bus driven while disabled");
    property p_outbound;
        @(posedge port_clock) disable iff (!resetn) !xfer_direction && !xfer_request_n |-> !dev_bus_oe;
    endproperty
    a_outbound: assert property (p_outbound) else $error("bus driven on outbound word");
    property p_addr_out;
        @(posedge port_clock) disable iff (!resetn)
        !addr_counter_load_n && !word_bus_output_disable_n && !$past(word_bus_output_disable_n)
        && !$past(word_bus_output_disable_n, 2) |-> dev_bus_oe;
    endproperty
    a_addr_out: assert property (p_addr_out) else $error("address not driven during load");
    property p_eop_pulse;
        @(posedge port_clock) disable iff (!resetn) $fell(end_of_process_n) |=> end_of_process_n;
    endproperty
    a_eop_pulse: assert property (p_eop_pulse) else $error("end strobe longer than one clock");
    property p_eop_idle;
        @(posedge port_clock) disable iff (!resetn) !end_of_process_n |-> xfer_request_n && addr_counter_load_n;
    endproperty
    a_eop_idle: assert property (p_eop_idle) else $error("end strobe during request");
    property p_reset_levels;
        @(posedge port_clock) (!resetn) [*5] |-> xfer_request_n && addr_counter_load_n && xfer_direction
        && !channel_select && !dev_bus_oe && end_of_process_n;
    endproperty
    a_reset_levels: assert property (p_reset_levels) else $error("wrong link levels in reset");
endmodule : lbp_link_properties

//--- verif/tb.sv
/*
 bench of the transfer buffer port: device and buffer logic joined by the link.
 assumes the design files; device inputs change on mclk falling edges, bus_disable and buf_ready on port_clock falling edges.
*/
`timescale 1ns/1ps
module tb;
    logic                 mclk = 1'h0;
    logic                 port_clock = 1'h0;
    logic                 resetn = 1'h0;
    logic                 cmd_valid = 1'h0, cmd_ready, cmd_channel = 1'h0, cmd_dir = 1'h0;
    logic [15:0]          cmd_addr = 16'h0, cmd_count = 16'h0, wr_data = 16'h0, rd_data, d;
    logic                 abort = 1'h0, wr_valid = 1'h0, wr_ready, rd_valid, rd_ready = 1'h0, xfer_done;
    logic                 bus_disable = 1'h0, buf_ready = 1'h1, buf_rd, buf_wr, cur_channel;
    logic [15:0]          buf_rd_addr, buf_wr_addr, buf_wdata, start_addr;
    logic                 seen_dir, seen_chan, eop_prev = 1'h1, host_end;
    logic [15:0]          wr_q[$], rd_q[$];
    int                   err_total = 0, comparisons = 0, eop_count = 0, end_seen = 0;

    always #2.5 mclk = ~mclk;
    always begin
        if ($time == 0) #1.3;
        #15 port_clock = ~port_clock;
    end

    lbp_link_if i_lbp_link_if (.port_clock(port_clock));
    lbp_device i_lbp_device (.mclk, .resetn, .clk_en(1'h1), .cmd_valid, .cmd_ready, .cmd_channel, .cmd_dir,
        .cmd_addr, .cmd_count, .abort, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data,
        .xfer_done, .link(i_lbp_link_if));
    lbp_host i_lbp_host (.resetn, .clk_en(1'h1), .bus_disable, .buf_ready, .buf_rdata(buf_rd_addr ^ 16'ha5a5),
        .buf_rd_addr, .buf_rd, .buf_wr_addr, .buf_wdata, .buf_wr, .start_addr, .cur_channel, .xfer_end(host_end),
        .link(i_lbp_link_if));
    lbp_link_properties i_lbp_link_properties (.port_clock(port_clock), .resetn(resetn),
        .xfer_request_n(i_lbp_link_if.xfer_request_n), .xfer_acknowledge_n(i_lbp_link_if.xfer_acknowledge_n),
        .addr_counter_load_n(i_lbp_link_if.addr_counter_load_n), .xfer_direction(i_lbp_link_if.xfer_direction),
        .channel_select(i_lbp_link_if.channel_select), .dev_bus_oe(i_lbp_link_if.dev_bus_oe),
        .word_bus_output_disable_n(i_lbp_link_if.word_bus_output_disable_n),
        .end_of_process_n(i_lbp_link_if.end_of_process_n));

    // link monitor at the settled half of the link clock
    always @(negedge port_clock) begin
        if (buf_wr === 1'h1) wr_q.push_back(buf_wdata);
        // counter has already moved past the word just read
        if (buf_rd === 1'h1) rd_q.push_back((buf_rd_addr - 16'h1) ^ 16'ha5a5);
        if (!i_lbp_link_if.xfer_request_n || !i_lbp_link_if.addr_counter_load_n) begin
            seen_dir = i_lbp_link_if.xfer_direction;
            seen_chan = i_lbp_link_if.channel_select;
        end
        if (eop_prev && !i_lbp_link_if.end_of_process_n) eop_count++;
        if (host_end === 1'h1) end_seen++;
        eop_prev = i_lbp_link_if.end_of_process_n;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic run_cmd(input logic chan, input logic dir, input logic [15:0] addr, input logic [15:0] cnt);
        @(negedge mclk);
        wr_q.delete();
        rd_q.delete();
        cmd_valid = 1'h1;
        cmd_channel = chan;
        cmd_dir = dir;
        cmd_addr = addr;
        cmd_count = cnt;
        @(posedge mclk);
        while (cmd_ready !== 1'h1) @(posedge mclk);
        @(negedge mclk);
        cmd_valid = 1'h0;
    endtask : run_cmd

    task automatic put_word(input logic [15:0] w);
        @(negedge mclk);
        wr_valid = 1'h1;
        wr_data = w;
        @(posedge mclk);
        while (wr_ready !== 1'h1) @(posedge mclk);
        @(negedge mclk);
        wr_valid = 1'h0;
    endtask : put_word

    task automatic get_word(output logic [15:0] w);
        @(negedge mclk);
        rd_ready = 1'h1;
        @(posedge mclk);
        while (rd_valid !== 1'h1) @(posedge mclk);
        w = rd_data;
        @(negedge mclk);
        rd_ready = 1'h0;
    endtask : get_word

    task automatic end_test(input string name, input logic chan, input logic dir, input int eops);
        @(posedge mclk);
        while (xfer_done !== 1'h1) @(posedge mclk);
        check("ready after done", 16'(cmd_ready), 16'h1);
        repeat (40) @(negedge mclk);
        check("direction", 16'(seen_dir), 16'(dir));
        check("channel", 16'(seen_chan), 16'(chan));
        check("end strobes", 16'(eop_count), 16'(eops));
        check("host end strobes", 16'(end_seen), 16'(eops));
        check("buffer channel", 16'(cur_channel), 16'(chan));
        check("request idle", 16'(i_lbp_link_if.xfer_request_n), 16'h1);
        $display("test %s done", name);
    endtask : end_test

    initial begin
        #100000;
        err_total++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        repeat (12) @(negedge port_clock);
        @(negedge mclk);
        resetn = 1'h1;
        // three words into the board on channel 1
        run_cmd(lbp_pkg::CHAN_1, lbp_pkg::DIR_TO_BOARD, 16'h1200, 16'h3);
        for (int i = 0; i < 3; i++) put_word(16'hc0d0 + 16'(i));
        end_test("to board", lbp_pkg::CHAN_1, lbp_pkg::DIR_TO_BOARD, 1);
        check("start address", start_addr, 16'h1200);
        check("word count", 16'(wr_q.size()), 16'h3);
        for (int i = 0; i < 3; i++) check("board word", wr_q[i], 16'hc0d0 + 16'(i));
        check("last buffer address", buf_wr_addr, 16'h1202);
        // two words out of the board on channel 0, buffer stalled first
        @(negedge port_clock);
        buf_ready = 1'h0;
        run_cmd(lbp_pkg::CHAN_0, lbp_pkg::DIR_FROM_BOARD, 16'h0040, 16'h2);
        repeat (60) @(negedge mclk);
        @(negedge port_clock);
        buf_ready = 1'h1;
        for (int i = 0; i < 2; i++) begin
            get_word(d);
            check("outbound word", d, rd_q[i]);
        end
        end_test("from board", lbp_pkg::CHAN_0, lbp_pkg::DIR_FROM_BOARD, 2);
        check("first buffer address", rd_q[0], 16'h0040 ^ 16'ha5a5);
        // bus disabled for a whole inbound command: pull-up seen
        @(negedge port_clock);
        bus_disable = 1'h1;
        run_cmd(lbp_pkg::CHAN_0, lbp_pkg::DIR_TO_BOARD, 16'h2468, 16'h1);
        put_word(16'h1357);
        end_test("disabled bus", lbp_pkg::CHAN_0, lbp_pkg::DIR_TO_BOARD, 3);
        check("disabled address", start_addr, lbp_pkg::BUS_PULLUP);
        check("disabled word", wr_q[0], lbp_pkg::BUS_PULLUP);
        @(negedge port_clock);
        bus_disable = 1'h0;
        // abort after the first of four outbound words
        run_cmd(lbp_pkg::CHAN_1, lbp_pkg::DIR_FROM_BOARD, 16'h0300, 16'h4);
        get_word(d);
        check("word before abort", d, rd_q[0]);
        abort = 1'h1;
        rd_ready = 1'h1;
        end_test("abort", lbp_pkg::CHAN_1, lbp_pkg::DIR_FROM_BOARD, 4);
        abort = 1'h0;
        rd_ready = 1'h0;
        summarize();
    end
endmodule : tb
